//--- core/mirq_pkg.sv
package mirq_pkg;

	// Register byte addresses
	localparam logic [7:0] OFS_FIRST_DATA_ROUTE   = 8'h00;
	localparam logic [7:0] OFS_FIRST_MOTION_ROUTE = 8'h04;
	localparam logic [7:0] OFS_SECOND_DATA_ROUTE  = 8'h08;
	localparam logic [7:0] OFS_SECOND_MOTION_ROUTE = 8'h0c;
	localparam logic [7:0] OFS_PIN_CONTROL        = 8'h10;
	localparam logic [7:0] OFS_COMBINED_SOURCE    = 8'h14;
	localparam logic [7:0] OFS_WAKE_SOURCE        = 8'h18;
	localparam logic [7:0] OFS_TAP_SOURCE         = 8'h1c;
	localparam logic [7:0] OFS_ORIENT_SOURCE      = 8'h20;
	localparam logic [7:0] OFS_READY_STATUS       = 8'h24;
	localparam logic [7:0] OFS_QUEUE_STATUS_TWO   = 8'h28;
	localparam logic [7:0] OFS_AUX_STATUS         = 8'h2c;

	// Pin control register fields
	localparam int CTL_POLARITY_LOW = 0;
	localparam int CTL_DRIVE_TYPE   = 1;
	localparam int CTL_MERGE_PINS   = 2;
	localparam int CTL_LATCH_IRQ    = 3;
	localparam int CTL_CLEAR_ON_READ = 4;
	localparam int CTL_BASIC_ENABLE = 5;

	// Bit positions in the motion route registers
	localparam int MOT_ACTIVITY    = 7;
	localparam int MOT_SINGLE_TAP  = 6;
	localparam int MOT_WAKE        = 5;
	localparam int MOT_FREEFALL    = 4;
	localparam int MOT_DOUBLE_TAP  = 3;
	localparam int MOT_ORIENTATION = 2;
	localparam int MOT_EMBEDDED    = 1;
	localparam int MOT_HUB_OR_TIME = 0;

	// Basic event masks, in motion route layout
	localparam logic [7:0] MASK_ALL_BASIC  = 8'hfc;
	localparam logic [7:0] MASK_WAKE_SRC   = 8'hb0;
	localparam logic [7:0] MASK_TAP_EVENT_SOURCE    = 8'h48;
	localparam logic [7:0] MASK_ORIENT_SRC = 8'h04;

	// Second data route: top bit reserved
	localparam logic [7:0] SECOND_DATA_WMASK = 8'h7f;

	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [5:0] CTL_RESET   = 6'h00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

endpackage

//--- core/mirq_pin_router.sv
// Overview of operation
// - Polarity bit zero active high, one low
// - Drive bit one makes pins open drain
// - First data route register selects pin-one sources
// - First motion route register selects motion sources
// - Second data route register, top bit zero
// - Second motion route, bit zero timestamp
// - Route bits reset zero; one connects source
// - Shared pin is OR of selected events
// - Every routable event readable as status
// - Combined source register reports all basic events
// - Merge bit ORs both pins onto first
// - Basic events silent until master enable set
// - Latched event holds until source register read
// - Unrouted function never latches
// - Clear-on-read clears at once, else next tick
// - Unlatched event drops when condition ends
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module mirq_pin_router
	import mirq_pkg::*;
(
	input  wire logic        clock,          // System clock, 50 MHz
	input  wire logic        sys_rst,        // Async reset, active high
	input  wire logic        hsel,           // AHB slave select
	input  wire logic [31:0] haddr,          // AHB address
	input  wire logic [1:0]  htrans,         // AHB transfer type
	input  wire logic        hwrite,         // AHB write
	input  wire logic [2:0]  hsize,          // AHB size, word only
	input  wire logic [31:0] hwdata,         // AHB write data
	input  wire logic        hready,         // AHB bus ready
	output logic             hreadyout,      // Slave ready, never waits
	output logic             hresp,          // Always OKAY
	output logic [31:0]      hrdata,         // Read data
	input  wire logic        sampleTick,     // One pulse per output sample
	input  wire logic        accelReady,     // Accelerometer data ready
	input  wire logic        gyroReady,      // Gyroscope data ready
	input  wire logic        tempReady,      // Temperature data ready
	input  wire logic        bootEvent,      // Boot in progress
	input  wire logic        markerReady,    // Marker-gated data ready
	input  wire logic        batchCount,     // Batch counter event
	input  wire logic        queueFull,      // Queue full
	input  wire logic        queueOverrun,   // Queue overrun
	input  wire logic        queueThreshold, // Queue threshold reached
	input  wire logic        embeddedEvent,  // Embedded function event
	input  wire logic        hubDone,        // Sensor hub end of operation
	input  wire logic        timeOverflow,   // Timestamp overflow alert
	input  wire logic        activityEvent,  // Activity change condition
	input  wire logic        singleTapEvent, // Single tap condition
	input  wire logic        wakeEvent,      // Wake-up condition
	input  wire logic        freefallEvent,  // Free-fall condition
	input  wire logic        doubleTapEvent, // Double tap condition
	input  wire logic        orientEvent,    // Orientation condition
	output logic             firstIrqOut,    // First pin level
	output logic             firstIrqOe,     // First pin driven
	output logic             secondIrqOut,   // Second pin level
	output logic             secondIrqOe     // Second pin driven
);

	typedef struct packed {
		logic [7:0]  dataRoute1;
		logic [7:0]  motRoute1;
		logic [6:0]  dataRoute2;
		logic [7:0]  motRoute2;
		logic [5:0]  ctl;
		logic [7:0]  basicHeld;
		logic [7:0]  clrPend;
		logic [7:0]  data1Stat;
		logic [7:0]  data2Stat;
		logic        embStat;
		logic        hubStat;
		logic        timeStat;
		logic        wrPend;
		logic [7:0]  wrAddr;
		logic [31:0] rdata;
		logic        pin1Out;
		logic        pin1Oe;
		logic        pin2Out;
		logic        pin2Oe;
	} mirq_state_t;

	mirq_state_t st;
	mirq_state_t next_st;

	// Basic event bits cleared by reading a source register
	function automatic logic [7:0] readClearMask(input logic [7:0] addr);
		unique case (addr)
			OFS_COMBINED_SOURCE: readClearMask = MASK_ALL_BASIC;
			OFS_WAKE_SOURCE:     readClearMask = MASK_WAKE_SRC;
			OFS_TAP_SOURCE:      readClearMask = MASK_TAP_EVENT_SOURCE;
			OFS_ORIENT_SOURCE:   readClearMask = MASK_ORIENT_SRC;
			default:             readClearMask = 8'h00;
		endcase
	endfunction

	// Drive level and enable for one pin from its asserted state
	function automatic logic [1:0] pinDrive(input logic act,
			input logic polLow, input logic openDrain);
		logic lvl;
		lvl = act ^ polLow;
		pinDrive = {lvl, act | ~openDrain};
	endfunction

	// Registers live in the low 256 bytes only
	function automatic logic inWindow(input logic [31:0] addr);
		inWindow = (addr[31:8] == 24'h000000);
	endfunction

	// Motion vector of one pin; its bit zero source differs per pin
	function automatic logic [7:0] motionVector(input logic [7:0] held,
			input logic emb, input logic lowBit);
		logic [7:0] v;
		v = held;
		v[MOT_EMBEDDED] = emb;
		v[MOT_HUB_OR_TIME] = lowBit;
		motionVector = v;
	endfunction

	// A pin is asserted when any routed source is set
	function automatic logic routeHit(input logic [7:0] route,
			input logic [7:0] stat);
		routeHit = |(route & stat);
	endfunction

	logic        addrPhase;
	logic [7:0]  addrIdx;
	logic [7:0]  basicLive;
	logic [7:0]  routedAny;
	logic [7:0]  latchMask;
	logic [7:0]  rdClr;
	logic [7:0]  motVec1;
	logic [7:0]  motVec2;
	logic        raw1;
	logic        raw2;
	logic [1:0]  drv1;
	logic [1:0]  drv2;
	logic        readHit;
	logic        writeHit;
	logic [7:0]  data1Now;
	logic [7:0]  data2Now;

	assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign addrIdx   = {haddr[7:2], 2'b00};
	assign readHit   = addrPhase & ~hwrite & inWindow(haddr);
	assign writeHit  = addrPhase & hwrite & inWindow(haddr);

	// Data-ready and queue events in route register layout
	assign data1Now = {markerReady, batchCount, queueFull, queueOverrun,
		queueThreshold, bootEvent, gyroReady, accelReady};
	assign data2Now = {1'b0, batchCount, queueFull, queueOverrun,
		queueThreshold, tempReady, gyroReady, accelReady};

	always_comb begin
		next_st = st;
		// Write data phase
		if (st.wrPend) begin
			unique case (st.wrAddr)
				OFS_FIRST_DATA_ROUTE:    next_st.dataRoute1 = hwdata[7:0];
				OFS_FIRST_MOTION_ROUTE:  next_st.motRoute1 = hwdata[7:0];
				OFS_SECOND_DATA_ROUTE:
					next_st.dataRoute2 = hwdata[6:0];
				OFS_SECOND_MOTION_ROUTE: next_st.motRoute2 = hwdata[7:0];
				OFS_PIN_CONTROL:         next_st.ctl = hwdata[5:0];
				default:                 next_st.wrPend = 1'b0;
			endcase
		end
		next_st.wrPend = writeHit;
		next_st.wrAddr = addrIdx;

		// Read captured in the address phase, before any clear
		next_st.rdata = st.rdata;
		if (addrPhase & ~hwrite) begin
			next_st.rdata = 32'h00000000;
			if (inWindow(haddr)) begin
				unique case (addrIdx)
					OFS_FIRST_DATA_ROUTE:
						next_st.rdata[7:0] = st.dataRoute1;
					OFS_FIRST_MOTION_ROUTE:
						next_st.rdata[7:0] = st.motRoute1;
					OFS_SECOND_DATA_ROUTE:
						next_st.rdata[7:0] = {1'b0, st.dataRoute2};
					OFS_SECOND_MOTION_ROUTE:
						next_st.rdata[7:0] = st.motRoute2;
					OFS_PIN_CONTROL:
						next_st.rdata[5:0] = st.ctl;
					OFS_COMBINED_SOURCE:
						next_st.rdata[7:0] = st.basicHeld & MASK_ALL_BASIC;
					OFS_WAKE_SOURCE:
						next_st.rdata[7:0] = st.basicHeld & MASK_WAKE_SRC;
					OFS_TAP_SOURCE:
						next_st.rdata[7:0] = st.basicHeld & MASK_TAP_EVENT_SOURCE;
					OFS_ORIENT_SOURCE:
						next_st.rdata[7:0] = st.basicHeld & MASK_ORIENT_SRC;
					OFS_READY_STATUS:
						next_st.rdata[8:0] = {st.data2Stat[2], st.data1Stat};
					OFS_QUEUE_STATUS_TWO:
						next_st.rdata[3:0] = st.data1Stat[6:3];
					OFS_AUX_STATUS:
						next_st.rdata[2:0] = {st.timeStat, st.hubStat,
							st.embStat};
					default:
						next_st.rdata = 32'h00000000;
				endcase
			end
		end

		// Basic events gated by master enable
		basicLive = {activityEvent, singleTapEvent, wakeEvent,
			freefallEvent, doubleTapEvent, orientEvent, 2'b00}
			& {8{st.ctl[CTL_BASIC_ENABLE]}};
		routedAny = (st.motRoute1 | st.motRoute2) & MASK_ALL_BASIC;
		latchMask = routedAny & {8{st.ctl[CTL_LATCH_IRQ]}};

		rdClr = 8'h00;
		if (readHit) begin
			rdClr = readClearMask(addrIdx) & latchMask;
		end
		if (st.ctl[CTL_CLEAR_ON_READ]) begin
			next_st.basicHeld = st.basicHeld & ~rdClr;
			next_st.clrPend = st.clrPend;
		end else begin
			next_st.basicHeld = st.basicHeld;
			next_st.clrPend = st.clrPend | rdClr;
		end

		// Sample tick: set wins over a clear in the same cycle
		if (sampleTick) begin
			next_st.basicHeld = (next_st.basicHeld & latchMask
				& ~next_st.clrPend) | basicLive;
			next_st.clrPend = 8'h00;
			next_st.data1Stat = data1Now;
			next_st.data2Stat = data2Now;
			next_st.embStat = embeddedEvent;
			next_st.hubStat = hubDone;
			next_st.timeStat = timeOverflow;
		end

		// Pin combination from the updated status
		motVec1 = motionVector(next_st.basicHeld, next_st.embStat,
			next_st.hubStat);
		motVec2 = motionVector(next_st.basicHeld, next_st.embStat,
			next_st.timeStat);
		raw1 = routeHit(st.dataRoute1, next_st.data1Stat)
			| routeHit(st.motRoute1, motVec1);
		raw2 = routeHit({1'b0, st.dataRoute2}, next_st.data2Stat)
			| routeHit(st.motRoute2, motVec2);
		if (st.ctl[CTL_MERGE_PINS]) begin
			raw1 = raw1 | raw2;
			raw2 = 1'b0;
		end
		drv1 = pinDrive(raw1, st.ctl[CTL_POLARITY_LOW],
			st.ctl[CTL_DRIVE_TYPE]);
		drv2 = pinDrive(raw2, st.ctl[CTL_POLARITY_LOW],
			st.ctl[CTL_DRIVE_TYPE]);
		next_st.pin1Out = drv1[1];
		next_st.pin1Oe = drv1[0];
		next_st.pin2Out = drv2[1];
		next_st.pin2Oe = drv2[0];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st.dataRoute1 <= ROUTE_RESET;
			st.motRoute1  <= ROUTE_RESET;
			st.dataRoute2 <= ROUTE_RESET[6:0];
			st.motRoute2  <= ROUTE_RESET;
			st.ctl        <= CTL_RESET;
			st.basicHeld  <= 8'h00;
			st.clrPend    <= 8'h00;
			st.data1Stat  <= 8'h00;
			st.data2Stat  <= 8'h00;
			st.embStat    <= 1'b0;
			st.hubStat    <= 1'b0;
			st.timeStat   <= 1'b0;
			st.wrPend     <= 1'b0;
			st.wrAddr     <= 8'h00;
			st.rdata      <= 32'h00000000;
			// Idle push-pull at the inactive level
			st.pin1Out    <= 1'b0;
			st.pin1Oe     <= 1'b1;
			st.pin2Out    <= 1'b0;
			st.pin2Oe     <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign hreadyout    = 1'b1;
	assign hresp        = HRESP_OKAY;
	assign hrdata       = st.rdata;
	assign firstIrqOut  = st.pin1Out;
	assign firstIrqOe   = st.pin1Oe;
	assign secondIrqOut = st.pin2Out;
	assign secondIrqOe  = st.pin2Oe;

endmodule

`default_nettype wire

//--- dv/mirq_host_lines.sv
`timescale 1ns/1ns
`default_nettype none

module mirq_host_lines (
	input  wire logic firstOut,   // Pin one level
	input  wire logic firstOe,    // Pin one driven
	input  wire logic secondOut,  // Pin two level
	input  wire logic secondOe,   // Pin two driven
	input  wire logic pullHigh,   // Board pull level
	output logic      firstLine,  // Line seen by host
	output logic      secondLine  // Line seen by host
);
	// Released line settles to the board pull
	assign firstLine  = firstOe ? firstOut : pullHigh;
	assign secondLine = secondOe ? secondOut : pullHigh;
endmodule

`default_nettype wire

//--- dv/mirq_pin_router_chk.sv
`timescale 1ns/1ns
`default_nettype none

module mirq_pin_router_chk
	import mirq_pkg::*;
(
	input wire logic        clock,        // Clock
	input wire logic        sys_rst,      // Reset
	input wire logic        hsel,         // Select
	input wire logic [31:0] haddr,        // Address
	input wire logic [1:0]  htrans,       // Transfer
	input wire logic        hwrite,       // Write
	input wire logic [31:0] hwdata,       // Write data
	input wire logic        hready,       // Ready in
	input wire logic        hreadyout,    // Ready out
	input wire logic        hresp,        // Response
	input wire logic        sampleTick,   // Tick
	input wire logic        firstIrqOut,  // Pin one
	input wire logic        firstIrqOe,   // Pin one drive
	input wire logic        secondIrqOut, // Pin two
	input wire logic        secondIrqOe   // Pin two drive
);
	logic       wrPend;
	logic [7:0] wrAddr;
	logic [5:0] ctl;
	logic       take;
	assign take = hsel && hready && htrans == HTRANS_NONSEQ;
	// Shadow of the pin control register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			ctl    <= 6'h00;
		end else begin
			wrPend <= take && hwrite;
			wrAddr <= haddr[7:0];
			if (wrPend && wrAddr == OFS_PIN_CONTROL)
				ctl <= hwdata[5:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_okay; hresp == HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_reset; $fell(sys_rst) |-> !firstIrqOut && firstIrqOe
		&& !secondIrqOut && secondIrqOe; endproperty
	a_reset: assert property (p_reset) else $error("pins not idle");
	property p_stable; !sampleTick && !take && !wrPend
		&& !$past(wrPend) |=>
		$stable({firstIrqOut, firstIrqOe, secondIrqOut, secondIrqOe}); endproperty
	a_stable: assert property (p_stable) else $error("pin off tick");
	property p_pushpull; sampleTick && !wrPend && !ctl[1] |=>
		firstIrqOe && secondIrqOe; endproperty
	a_pushpull: assert property (p_pushpull) else $error("pin released");
	property p_odone; sampleTick && !wrPend && ctl[1] |=>
		firstIrqOut == (firstIrqOe ^ ctl[0]); endproperty
	a_odone: assert property (p_odone) else $error("pin one level");
	property p_odtwo; sampleTick && !wrPend && ctl[1] |=>
		secondIrqOut == (secondIrqOe ^ ctl[0]); endproperty
	a_odtwo: assert property (p_odtwo) else $error("pin two level");
	property p_idle; !firstIrqOe && !secondIrqOe |-> firstIrqOut == secondIrqOut;
	endproperty
	a_idle: assert property (p_idle) else $error("idle levels differ");
	property p_merge; sampleTick && !wrPend && ctl[2] |=> secondIrqOut == ctl[0];
	endproperty
	a_merge: assert property (p_merge) else $error("pin two active");
endmodule

bind mirq_pin_router mirq_pin_router_chk i_chk (.clock, .sys_rst, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
	.sampleTick, .firstIrqOut, .firstIrqOe, .secondIrqOut, .secondIrqOe);

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	import mirq_pkg::*;
	logic        clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [17:0] ev = 18'h0;
	logic        sampleTick = 1'b0, pullHigh = 1'b0, hready, hresp;
	logic        o1, e1, o2, e2, fl, sl;
	int          n_errors = 0, tests_run = 0;
	always #10 clock = ~clock;
	mirq_pin_router i_dut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
		.sampleTick, .accelReady(ev[0]), .gyroReady(ev[1]), .bootEvent(ev[2]),
		.queueThreshold(ev[3]), .queueOverrun(ev[4]), .queueFull(ev[5]),
		.batchCount(ev[6]), .markerReady(ev[7]), .hubDone(ev[8]),
		.embeddedEvent(ev[9]), .orientEvent(ev[10]), .doubleTapEvent(ev[11]),
		.freefallEvent(ev[12]), .wakeEvent(ev[13]), .singleTapEvent(ev[14]),
		.activityEvent(ev[15]), .tempReady(ev[16]), .timeOverflow(ev[17]),
		.firstIrqOut(o1), .firstIrqOe(e1), .secondIrqOut(o2), .secondIrqOe(e2));
	mirq_host_lines i_host (.firstOut(o1), .firstOe(e1), .secondOut(o2),
		.secondOe(e2), .pullHigh, .firstLine(fl), .secondLine(sl));
	task automatic chk(input string nm, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic tk(input logic [17:0] x);
		@(posedge clock);
		ev <= x;
		sampleTick <= 1'b1;
		@(posedge clock);
		sampleTick <= 1'b0;
		#1;
	endtask
	task automatic t_regs;
		for (int r = 0; r < 4; r++) begin
			bus(0, 8'(r * 4), 0);
			chk("route reset", 0, rd);
			bus(1, 8'(r * 4), 32'hff);
			bus(0, 8'(r * 4), 0);
			chk("route rw", r == 2 ? 32'h7f : 32'hff, rd);
			bus(1, 8'(r * 4), 0);
		end
		bus(0, 8'h30, 0);
		chk("unmapped", 0, rd);
	endtask
	task automatic t_route;
		int idx;
		bus(1, OFS_PIN_CONTROL, 32'h20);
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 8; i++) begin
				idx = (r % 2) * 8 + i;
				if (r == 2 && i == 2) idx = 16;
				if (r == 3 && i == 0) idx = 17;
				if (r == 2 && i == 7) continue;
				bus(1, 8'(r * 4), 32'(1 << i));
				tk(18'(1 << idx));
				chk("pin one", r < 2, fl);
				chk("pin two", r >= 2, sl);
				tk(~18'(1 << idx));
				chk("pin one other", 0, fl);
				chk("pin two other", 0, sl);
			end
			bus(1, 8'(r * 4), 0);
		end
	endtask
	task automatic t_merge;
		bus(1, OFS_FIRST_DATA_ROUTE, 32'h03);
		bus(1, OFS_SECOND_DATA_ROUTE, 32'h04);
		tk(18'h00002);
		chk("or", 1, fl);
		bus(1, OFS_PIN_CONTROL, 32'h24);
		tk(18'h10000);
		chk("merged one", 1, fl);
		chk("merged two", 0, sl);
		bus(1, OFS_PIN_CONTROL, 32'h20);
		tk(18'h10000);
		chk("split one", 0, fl);
		chk("split two", 1, sl);
		bus(1, OFS_FIRST_DATA_ROUTE, 0);
		bus(1, OFS_SECOND_DATA_ROUTE, 0);
	endtask
	task automatic t_enable;
		bus(1, OFS_PIN_CONTROL, 0);
		bus(1, OFS_FIRST_MOTION_ROUTE, 32'h10);
		tk(18'h01000);
		chk("disabled", 0, fl);
		bus(1, OFS_PIN_CONTROL, 32'h20);
		tk(18'h01000);
		chk("enabled", 1, fl);
		bus(0, OFS_COMBINED_SOURCE, 0);
		chk("combined", 32'h10, rd);
		tk(0);
		chk("unlatched drop", 0, fl);
	endtask
	// Source reads follow a pin event, except the final unrouted read
	task automatic t_latch;
		bus(1, OFS_PIN_CONTROL, 32'h28);
		tk(18'h01000);
		tk(0);
		chk("latched", 1, fl);
		bus(0, OFS_WAKE_SOURCE, 0);
		chk("wake source", 32'h10, rd);
		chk("held to tick", 1, fl);
		tk(0);
		chk("cleared at tick", 0, fl);
		bus(1, OFS_PIN_CONTROL, 32'h38);
		tk(18'h01000);
		tk(0);
		bus(0, OFS_COMBINED_SOURCE, 0);
		chk("pre-clear data", 32'h10, rd);
		chk("cleared on read", 0, fl);
		bus(1, OFS_FIRST_MOTION_ROUTE, 0);
		tk(18'h01000);
		tk(0);
		bus(0, OFS_WAKE_SOURCE, 0);
		chk("unrouted", 0, rd);
	endtask
	task automatic t_pol;
		bus(1, OFS_FIRST_MOTION_ROUTE, 32'h10);
		bus(1, OFS_PIN_CONTROL, 32'h21);
		tk(0);
		chk("low idle", 1, fl);
		tk(18'h01000);
		chk("low active", 0, fl);
		pullHigh <= 1'b1;
		bus(1, OFS_PIN_CONTROL, 32'h23);
		tk(0);
		chk("drain idle", 0, e1);
		chk("drain idle two", 0, e2);
		chk("drain idle line", 1, fl);
		tk(18'h01000);
		chk("drain active", 1, e1);
		chk("drain active line", 0, fl);
	endtask
	task automatic t_status;
		bus(1, OFS_PIN_CONTROL, 32'h20);
		tk(18'h3ffff);
		bus(0, OFS_PIN_CONTROL, 0);
		chk("control", 32'h20, rd);
		bus(0, OFS_READY_STATUS, 0);
		chk("ready status", 32'h1ff, rd);
		bus(0, OFS_QUEUE_STATUS_TWO, 0);
		chk("queue status", 32'hf, rd);
		bus(0, OFS_AUX_STATUS, 0);
		chk("aux status", 32'h7, rd);
		bus(0, OFS_COMBINED_SOURCE, 0);
		chk("all basic", 32'hfc, rd);
		bus(0, OFS_TAP_SOURCE, 0);
		chk("tap source", 32'h48, rd);
		bus(0, OFS_ORIENT_SOURCE, 0);
		chk("orient source", 32'h04, rd);
		tk(0);
		bus(0, OFS_READY_STATUS, 0);
		chk("ready cleared", 0, rd);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs;
		$display("regs done");
		t_route;
		$display("route done");
		t_merge;
		$display("merge done");
		t_enable;
		$display("enable done");
		t_latch;
		$display("latch done");
		t_pol;
		$display("polarity done");
		t_status;
		$display("status done");
		print_verdict;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		print_verdict;
	end
endmodule

`default_nettype wire
